//--- shared/afx_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface afx_dec_if;
	import afx_pkg::*;
	afx_instr_t instr;
	afx_op_e op;
	logic [4:0] faddr;
	logic dest;
	afx_byte_t lit;
	modport dec (input instr, output op, faddr, dest, lit);
	modport exe (output instr, input op, faddr, dest, lit);
endinterface
`default_nettype wire

//--- shared/afx_pkg.sv
`default_nettype none
package afx_pkg;
	typedef enum logic [2:0] {
		AFX_OP_NOP,
		AFX_OP_OR,
		AFX_OP_STORE,
		AFX_OP_COPY,
		AFX_OP_LIT,
		AFX_OP_OPTION,
		AFX_OP_DIRECTION_LATCH_LOAD,
		AFX_OP_BAD
	} afx_op_e;
	typedef logic [11:0] afx_instr_t;
	typedef logic [7:0] afx_byte_t;
endpackage
`default_nettype wire

//--- shared/afx_regs.svh
`ifndef AFX_REGS_SVH
`define AFX_REGS_SVH

// apb byte offsets
`define AFX_OFS_INSTR 8'h00
`define AFX_OFS_ACCUM 8'h04
`define AFX_OFS_STATUS 8'h08
`define AFX_OFS_OPTION 8'h0C
`define AFX_OFS_DIR 8'h10
`define AFX_OFS_PC 8'h14
`define AFX_OFS_PINS 8'h18
`define AFX_OFS_FILE 8'h80

// status register fields
`define AFX_ST_ZERO 0
`define AFX_ST_BAD 1

// file register addresses
`define AFX_F_TIMER 5'h01
`define AFX_F_PCL 5'h02
`define AFX_F_STATUS 5'h03
`define AFX_F_PORT 5'h06
`define AFX_F_ZERO_BIT 2

// option field: prescaler assignment, 0 means timer
`define AFX_OPT_PSA 3

// reset values
`define AFX_RST_OPTION 8'hFF
`define AFX_RST_DIR 8'hFF
`define AFX_RST_PC 9'h1FF

// opcode patterns
`define AFX_OPC_OR 6'h04
`define AFX_OPC_COPY 6'h08
`define AFX_OPC_STORE 7'h01
`define AFX_OPC_LIT 4'hC
`define AFX_OPC_NOP 12'h000
`define AFX_OPC_OPTION 12'h002
`define AFX_OPC_DIRECTION_LATCH_LOAD_HI 9'h000
`define AFX_DIRECTION_LATCH_LOAD_PORT 3'h6

`endif

//--- tb/afx_exec_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "afx_regs.svh"
module afx_exec_monitor #(
	parameter int PORT_W = 8
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// port pins
	input wire logic [PORT_W-1:0] port_pin_i,
	input wire logic [PORT_W-1:0] port_pin_o,
	input wire logic [PORT_W-1:0] port_pin_oe_o,
	// timer side
	input wire afx_pkg::afx_byte_t option_o,
	input wire logic presc_clr_o
);
	import afx_pkg::*;
	logic wr_instr;
	// instruction executes at this access edge
	assign wr_instr = psel_i && penable_i && pwrite_i && paddr_i == `AFX_OFS_INSTR;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);
	// literal load, then an accumulator read after one idle cycle
	sequence wr_lit;
		wr_instr && pwdata_i[11:8] == 4'hC;
	endsequence
	sequence rd_acc;
		psel_i && !penable_i && !pwrite_i && paddr_i == `AFX_OFS_ACCUM;
	endsequence
	chk_lit_accum: assert property (wr_lit ##2 rd_acc |=> prdata_o[7:0] == $past(pwdata_i[7:0], 3))
		else $error("literal not seen in accumulator");
	chk_option_src: assert property ($changed(option_o) |-> $past(wr_instr && pwdata_i[11:0] == 12'h002))
		else $error("option changed without option load");
	chk_dir_src: assert property ($changed(port_pin_oe_o) |-> $past(wr_instr && pwdata_i[11:0] == 12'h006))
		else $error("direction changed without direction load");
	chk_latch_src: assert property ($changed(port_pin_o) |-> $past(wr_instr && pwdata_i[4:0] == 5'h06))
		else $error("port latch changed without port write");
	chk_float_reset: assert property ($fell(srst_i) |-> port_pin_oe_o == '0)
		else $error("pins driven after reset");
	chk_presc_cause: assert property (presc_clr_o |-> $past(wr_instr && pwdata_i[4:0] == 5'h01 && !option_o[3]))
		else $error("prescaler clear without timer write");
	// store into the timer slot while the prescaler belongs to it, then a single-cycle clear
	sequence wr_timer_store;
		wr_instr && pwdata_i[11:0] == 12'h021 && !option_o[3];
	endsequence
	sequence clr_pulse;
		presc_clr_o ##1 !presc_clr_o;
	endsequence
	chk_presc_pulse: assert property (wr_timer_store |=> clr_pulse)
		else $error("prescaler clear pulse missing");
	// nop must leave option, port latch, direction and prescaler clear alone
	sequence nop_issue;
		wr_instr && pwdata_i[11:0] == 12'h000;
	endsequence
	chk_nop_quiet: assert property (nop_issue |=> $stable(option_o) && $stable(port_pin_o)
		&& $stable(port_pin_oe_o) && !presc_clr_o)
		else $error("nop changed state");
endmodule
bind afx_exec afx_exec_monitor #(.PORT_W(PORT_W)) afx_exec_monitor_i (
	.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .port_pin_i(port_pin_i), .port_pin_o(port_pin_o),
	.port_pin_oe_o(port_pin_oe_o), .option_o(option_o), .presc_clr_o(presc_clr_o)
);
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import afx_pkg::*;
	logic clk_sys_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, presc_clr_o;
	logic [7:0] paddr_i, port_pin_i, port_pin_o, port_pin_oe_o;
	logic [31:0] pwdata_i, prdata_o, r;
	logic slv;
	afx_byte_t option_o;
	int errors, n_compared;
	logic [7:0] lits [3] = '{8'h00, 8'h5A, 8'hFF};
	afx_exec afx_exec_i (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .port_pin_i(port_pin_i), .port_pin_o(port_pin_o),
		.port_pin_oe_o(port_pin_oe_o), .option_o(option_o), .presc_clr_o(presc_clr_o)
	);
	// 125 MHz
	initial begin
		clk_sys_i = 0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	// compare and count
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// one apb transfer, idle cycle after so psel never lingers
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (pready_o !== 1'b1) begin
			errors++;
			tally_and_finish();
		end
		r = prdata_o;
		slv = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		check(r, e);
	endtask
	task automatic ex(input logic [11:0] i);
		apb(1, 8'h00, {20'h0, i});
	endtask
	// main sequence
	initial begin
		srst_i = 1;
		psel_i = 0;
		penable_i = 0;
		pwrite_i = 0;
		paddr_i = 0;
		pwdata_i = 0;
		port_pin_i = 8'hA5;
		errors = 0;
		n_compared = 0;
		repeat (6) @(posedge clk_sys_i);
		srst_i <= 0;
		#1;
		check(port_pin_oe_o, 0);
		foreach (lits[k]) begin
			ex({4'hC, lits[k]});
			rd(8'h04, {24'h0, lits[k]});
		end
		rd(8'h08, 0);
		ex(12'h021);
		#1;
		check(presc_clr_o, 0);
		ex(12'h022);
		apb(0, 8'h14, 0);
		check(r[8], 0);
		ex(12'hC0F);
		ex(12'h029);
		ex(12'h03F);
		rd(8'hFC, 32'h0F);
		ex(12'hCF0);
		ex(12'h109);
		rd(8'h04, 32'hFF);
		rd(8'hA4, 32'h0F);
		ex(12'hC30);
		ex(12'h13F);
		rd(8'hFC, 32'h3F);
		rd(8'h08, 0);
		ex(12'hC00);
		ex(12'h10A);
		rd(8'h08, 1);
		ex(12'h209);
		rd(8'h04, 32'h0F);
		rd(8'h08, 0);
		ex(12'h22A);
		rd(8'h08, 1);
		ex(12'h000);
		ex(12'hC37);
		ex(12'h002);
		rd(8'h08, 1);
		check(option_o, 32'h37);
		ex(12'h021);
		#1;
		check(presc_clr_o, 1);
		ex(12'hCF0);
		ex(12'h006);
		#1;
		check(port_pin_oe_o, 32'h0F);
		ex(12'h226);
		#1;
		check(port_pin_o, 32'hA5);
		@(posedge clk_sys_i);
		port_pin_i <= 8'h0F;
		repeat (3) @(posedge clk_sys_i);
		ex(12'hC30);
		ex(12'h126);
		#1;
		check(port_pin_o, 32'h3F);
		// near-miss opcodes must only raise the bad flag
		ex(12'h1C9);
		ex(12'h005);
		ex(12'h004);
		rd(8'h04, 32'h30);
		rd(8'h08, 32'h2);
		check(port_pin_oe_o, 32'h0F);
		check(option_o, 32'h37);
		apb(1, 8'h08, 32'h2);
		rd(8'h08, 0);
		check(slv, 0);
		rd(8'h1C, 0);
		check(slv, 1);
		// second reset in mid-run: counter bit 8 is one again, so a lost force would show
		@(posedge clk_sys_i);
		srst_i <= 1;
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 0;
		ex(12'h022);
		rd(8'h14, 32'h000);
		tally_and_finish();
	end
endmodule
`default_nettype wire

//--- verilog/afx_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "afx_regs.svh"
module afx_decode (
	// decode channel
	afx_dec_if.dec dec
);
	import afx_pkg::*;

	// operand fields sit at fixed positions for every format
	assign dec.faddr = dec.instr[4:0];
	assign dec.dest = dec.instr[5];
	assign dec.lit = dec.instr[7:0];

	// pattern match; anything outside this subset is flagged bad
	always_comb begin
		if (dec.instr[11:6] == `AFX_OPC_OR) begin
			dec.op = AFX_OP_OR;
		end else if (dec.instr[11:6] == `AFX_OPC_COPY) begin
			dec.op = AFX_OP_COPY;
		end else if (dec.instr[11:5] == `AFX_OPC_STORE) begin
			dec.op = AFX_OP_STORE;
		end else if (dec.instr[11:8] == `AFX_OPC_LIT) begin
			dec.op = AFX_OP_LIT;
		end else if (dec.instr == `AFX_OPC_NOP) begin
			dec.op = AFX_OP_NOP;
		end else if (dec.instr == `AFX_OPC_OPTION) begin
			dec.op = AFX_OP_OPTION;
		end else if (dec.instr[11:3] == `AFX_OPC_DIRECTION_LATCH_LOAD_HI && dec.instr[2:0] == `AFX_DIRECTION_LATCH_LOAD_PORT) begin
			dec.op = AFX_OP_DIRECTION_LATCH_LOAD;
		end else begin
			dec.op = AFX_OP_BAD;
		end
	end
endmodule
`default_nettype wire

//--- verilog/afx_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "afx_regs.svh"
// Operation
// - file writes to the program counter force its ninth bit to zero
// - reads of the I/O port take pin levels, not the data latch
// - direction load with operand six copies accumulator to port direction latches
// - a direction bit at one floats its pin, output driver off
// - marked writes to timer clear prescaler when prescaler belongs to timer
// - or instruction ORs accumulator with file register 0 to 31
// - or result goes to accumulator when d is zero, file when one
// - store instruction copies accumulator into addressed file register
// - copy instruction moves file value to accumulator or back to file
// - copy instruction updates zero flag from moved value
// - literal instruction loads eight-bit literal into accumulator
// - option instruction copies accumulator into timer option register
// - or instruction decoded from pattern 0001 00df ffff
// - option instruction decoded from pattern 0000 0000 0010
module afx_exec #(
	parameter int PORT_W = 8
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// second io port pins
	input wire logic [PORT_W-1:0] port_pin_i,
	output logic [PORT_W-1:0] port_pin_o,
	output logic [PORT_W-1:0] port_pin_oe_o,
	// timer side
	output afx_pkg::afx_byte_t option_o,
	output logic presc_clr_o
);
	import afx_pkg::*;

	afx_dec_if dec_if ();

	afx_byte_t accum_reg;
	afx_byte_t option_reg;
	afx_byte_t dir_reg;
	afx_byte_t port_latch_reg;
	afx_byte_t timer_reg;
	afx_byte_t file_reg [32];
	afx_instr_t instr_reg;
	logic [8:0] pc_reg;
	logic zero_reg;
	logic bad_reg;
	logic presc_clr_reg;
	logic [31:0] prdata_reg;
	logic [PORT_W-1:0] pin_meta_reg;
	logic [PORT_W-1:0] pin_sync_reg;

	logic apb_setup;
	logic apb_wr;
	logic addr_ok;
	logic exec_go;
	afx_byte_t pins_byte;
	afx_byte_t fsrc;
	afx_byte_t res;
	logic wr_file;
	logic wr_acc;
	logic z_upd;
	logic opt_wr;
	logic dir_wr;
	logic bad_set;
	logic [31:0] rd_mux;

	afx_decode u_decode (
		.dec(dec_if.dec)
	);

	// instruction comes straight off the write data so it runs in the access cycle
	assign dec_if.instr = pwdata_i[11:0];

	// apb decode; zero wait states, read data latched in setup
	assign apb_setup = psel_i & ~penable_i;
	assign apb_wr = psel_i & penable_i & pwrite_i;
	assign exec_go = apb_wr & (paddr_i == `AFX_OFS_INSTR);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~addr_ok;
	assign prdata_o = prdata_reg;

	// legal word addresses: control block and the file window
	always_comb begin
		addr_ok = 1'b0;
		if (paddr_i[1:0] == 2'b00) begin
			if (paddr_i[7]) begin
				addr_ok = 1'b1;
			end else if (paddr_i <= `AFX_OFS_PINS) begin
				addr_ok = 1'b1;
			end
		end
	end

	// pins cross in through two flops; only the second one is read
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			pin_meta_reg <= port_pin_i;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// port value as the core sees it: the pins, never the latch
	always_comb begin
		pins_byte = 8'h00;
		pins_byte[PORT_W-1:0] = pin_sync_reg;
	end

	// file operand fetch; specials are mapped over the plain array
	always_comb begin
		case (dec_if.faddr)
			`AFX_F_TIMER: fsrc = timer_reg;
			`AFX_F_PCL: fsrc = pc_reg[7:0];
			`AFX_F_STATUS: begin
				fsrc = 8'h00;
				fsrc[`AFX_F_ZERO_BIT] = zero_reg;
			end
			`AFX_F_PORT: fsrc = pins_byte;
			default: fsrc = file_reg[dec_if.faddr];
		endcase
	end

	// execution: result, destination and flag enables per operation
	always_comb begin
		res = 8'h00;
		wr_file = 1'b0;
		wr_acc = 1'b0;
		z_upd = 1'b0;
		opt_wr = 1'b0;
		dir_wr = 1'b0;
		bad_set = 1'b0;
		case (dec_if.op)
			AFX_OP_OR: begin
				res = accum_reg | fsrc;
				wr_file = dec_if.dest;
				wr_acc = ~dec_if.dest;
				z_upd = 1'b1;
			end
			AFX_OP_STORE: begin
				res = accum_reg;
				wr_file = 1'b1;
			end
			AFX_OP_COPY: begin
				res = fsrc;
				wr_file = dec_if.dest;
				wr_acc = ~dec_if.dest;
				z_upd = 1'b1;
			end
			AFX_OP_LIT: begin
				res = dec_if.lit;
				wr_acc = 1'b1;
			end
			AFX_OP_OPTION: opt_wr = 1'b1;
			AFX_OP_DIRECTION_LATCH_LOAD: dir_wr = 1'b1;
			AFX_OP_NOP: bad_set = 1'b0; // no enables set; only the pc steps and instr_reg reloads
			AFX_OP_BAD: bad_set = 1'b1;
			default: bad_set = 1'b1;
		endcase
	end

	// accumulator: instruction result or direct software write
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			accum_reg <= 8'h00;
		end else if (exec_go && wr_acc) begin
			accum_reg <= res;
		end else if (apb_wr && paddr_i == `AFX_OFS_ACCUM) begin
			accum_reg <= pwdata_i[7:0];
		end
	end

	// plain file array; special addresses keep their own storage
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			for (int i = 0; i < 32; i++) begin
				file_reg[i] <= 8'h00;
			end
		end else if (exec_go && wr_file) begin
			file_reg[dec_if.faddr] <= res;
		end
	end

	// timer storage location in the file map
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			timer_reg <= 8'h00;
		end else if (exec_go && wr_file && dec_if.faddr == `AFX_F_TIMER) begin
			timer_reg <= res;
		end
	end

	// port data latch; what leaves on the pins
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			port_latch_reg <= 8'h00;
		end else if (exec_go && wr_file && dec_if.faddr == `AFX_F_PORT) begin
			port_latch_reg <= res; // built from pin levels on read-modify-write
		end
	end

	// zero flag: only or and copy touch it by result
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			zero_reg <= 1'b0;
		end else if (exec_go && z_upd) begin
			zero_reg <= (res == 8'h00); // flag wins over a status write
		end else if (exec_go && wr_file && dec_if.faddr == `AFX_F_STATUS) begin
			zero_reg <= res[`AFX_F_ZERO_BIT]; // plain data write, not a flag update
		end
	end

	// sticky unsupported-opcode flag; w1c, a new set beats the clear
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			bad_reg <= 1'b0;
		end else if (exec_go && bad_set) begin
			bad_reg <= 1'b1;
		end else if (apb_wr && paddr_i == `AFX_OFS_STATUS && pwdata_i[`AFX_ST_BAD]) begin
			bad_reg <= 1'b0;
		end
	end

	// option register load
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			option_reg <= `AFX_RST_OPTION;
		end else if (exec_go && opt_wr) begin
			option_reg <= accum_reg;
		end
	end

	// port direction latches
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			dir_reg <= `AFX_RST_DIR;
		end else if (exec_go && dir_wr) begin
			dir_reg <= accum_reg;
		end
	end

	// program counter: steps per instruction, file writes to PCL clear bit 8
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pc_reg <= `AFX_RST_PC;
		end else if (exec_go && wr_file && dec_if.faddr == `AFX_F_PCL) begin
			pc_reg <= {1'b0, res};
		end else if (exec_go) begin
			pc_reg <= pc_reg + 9'h001;
		end
	end

	// prescaler clear pulse; only d=1 forms and store reach the timer here
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			presc_clr_reg <= 1'b0;
		end else begin
			presc_clr_reg <= exec_go && wr_file && dec_if.faddr == `AFX_F_TIMER
				&& !option_reg[`AFX_OPT_PSA];
		end
	end

	// last issued instruction, kept for readback
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			instr_reg <= 12'h000;
		end else if (exec_go) begin
			instr_reg <= dec_if.instr;
		end
	end

	// read mux; the file window repeats the operand fetch mapping in its own case by address
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (paddr_i[7]) begin
			case (paddr_i[6:2])
				`AFX_F_TIMER: rd_mux[7:0] = timer_reg;
				`AFX_F_PCL: rd_mux[7:0] = pc_reg[7:0];
				`AFX_F_STATUS: rd_mux[`AFX_F_ZERO_BIT] = zero_reg;
				`AFX_F_PORT: rd_mux[7:0] = pins_byte;
				default: rd_mux[7:0] = file_reg[paddr_i[6:2]];
			endcase
		end else begin
			case (paddr_i)
				`AFX_OFS_INSTR: rd_mux[11:0] = instr_reg;
				`AFX_OFS_ACCUM: rd_mux[7:0] = accum_reg;
				`AFX_OFS_STATUS: rd_mux[1:0] = {bad_reg, zero_reg};
				`AFX_OFS_OPTION: rd_mux[7:0] = option_reg;
				`AFX_OFS_DIR: rd_mux[7:0] = dir_reg;
				`AFX_OFS_PC: rd_mux[8:0] = pc_reg;
				`AFX_OFS_PINS: rd_mux[7:0] = pins_byte;
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// capture read data in setup so the access phase sees a flop
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			prdata_reg <= 32'h0000_0000;
		end else if (apb_setup && !pwrite_i) begin
			prdata_reg <= rd_mux;
		end
	end

	// pin drivers: direction bit one floats the pin
	assign port_pin_o = port_latch_reg[PORT_W-1:0];
	assign port_pin_oe_o = ~dir_reg[PORT_W-1:0];
	assign option_o = option_reg;
	assign presc_clr_o = presc_clr_reg;
endmodule
`default_nettype wire
